// [pts_device.sv]
// Operation
// - Each address selects one 16-bit word
// - Type code selects area, addresses range-checked
// - Axis areas decoded from consecutive type codes
// - One transfer carries only one type
// - Host transfers whole data items
// - Block transfers only while controller runs
// - One sequence per block write
// - Transfer-bit path works in any mode
// - Host raises transfer bit to start
// - Working memory volatile, reloaded on restart
// - Save copies working memory to flash
// - Flash reloaded at start and setup end
// - Start-up parameters writable only by tool/setup
// - Block read of parameter areas refused
// - Save excludes attached slave data
// - Tool may download and upload everything
`timescale 1ns/100ps
module pts_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] cnt_ff;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_ff != FULL_CNT);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rd_ptr_ff];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module pts_device import pts_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Link to the host
  pts_if.dev link,
  // Status
  output logic loading,
  output logic saving
);
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b011,
    ST_SAVE = 3'b100
  } pts_state_t;

  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(STORE_WORDS - 1);
  localparam logic [IDX_W-1:0] IDX_AXIS0 = IDX_W'(COMMON_WORDS);

  logic [WORD_W-1:0] work [STORE_WORDS];
  logic [WORD_W-1:0] flash [STORE_WORDS];
  pts_state_t state_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [15:0] remain_ff;
  logic [15:0] type_ff;
  logic err_ff;
  logic save_pend_ff;
  logic load_pend_ff;
  logic rsp_valid_ff;
  logic rsp_err_ff;
  logic rsp_last_ff;
  logic [WORD_W-1:0] rsp_data_ff;
  logic busy_ff;
  logic loading_ff;
  logic saving_ff;

  pts_beat_t q;
  logic q_valid;
  wire q_pop;

  pts_fifo #(.WIDTH($bits(pts_beat_t)), .DEPTH(DEPTH)) u_fifo (
    .core_clk(link.core_clk),
    .rst(link.rst),
    .in_valid(link.req_valid),
    .in_ready(link.req_ready),
    .in_data(link.beat),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q)
  );
  // Header decode
  wire is_common = (q.ptype == TYPE_COMMON);
  wire is_axis = (q.ptype >= TYPE_AXIS_FIRST) &&
                 (q.ptype <= TYPE_AXIS_LAST);
  wire [16:0] end_addr = {1'b0, q.addr} + {1'b0, q.count} - 17'h00001;
  wire cnt_ok = (q.count != '0) && !end_addr[16];
  wire range_ok = cnt_ok && (is_common ?
    (q.addr >= COMMON_ADDR_MIN) && (end_addr[15:0] <= COMMON_ADDR_MAX) :
    is_axis && (end_addr[15:0] <= AXIS_ADDR_MAX));
  wire blk_ok = q.write && link.host_running;
  wire method_ok = (q.method == PTS_TOOL) ||
                   (q.method == PTS_BITS && link.xfer_bit) ||
                   (q.method == PTS_BLOCK && blk_ok);
  wire boot_hit = is_common && (q.addr <= BOOT_ONLY_MAX);
  wire boot_ok = !boot_hit || !q.write || (q.method == PTS_TOOL) ||
                 (q.method == PTS_BITS && link.setup_mode);
  wire hdr_ok = q.first && range_ok && method_ok && boot_ok;
  wire [15:0] axis_sel = q.ptype - TYPE_AXIS_FIRST;
  wire [IDX_W-1:0] base_idx = is_common ? q.addr[IDX_W-1:0] :
    IDX_AXIS0 + IDX_W'(int'(axis_sel[3:0]) * AXIS_WORDS) +
    q.addr[IDX_W-1:0];

  wire in_idle_raw = (state_ff == ST_IDLE);
  wire in_idle = in_idle_raw && !save_pend_ff && !load_pend_ff;
  assign q_pop = q_valid && (in_idle || state_ff == ST_WRITE);
  wire hdr_take = q_pop && in_idle;
  wire beat_take = q_pop && (state_ff == ST_WRITE);
  wire beat_ok = !err_ff && !q.first && (q.ptype == type_ff);
  wire hdr_we = hdr_take && hdr_ok && q.write;
  wire beat_we = beat_take && beat_ok;
  wire load_we = (state_ff == ST_LOAD);
  wire save_we = (state_ff == ST_SAVE);
  wire work_we = hdr_we || beat_we || load_we;
  wire [IDX_W-1:0] work_idx = hdr_we ? base_idx : idx_ff;
  wire [WORD_W-1:0] work_wd = load_we ? flash[idx_ff] : q.data;
  wire copy_end = (idx_ff == IDX_LAST);

  // Working memory takes host words and reloads from flash
  always_ff @(posedge link.core_clk) begin
    if (work_we) begin
      work[work_idx] <= work_wd;
    end
  end

  // Only this block's own store is saved; slave data has its own path
  always_ff @(posedge link.core_clk) begin
    if (save_we) begin
      flash[idx_ff] <= work[idx_ff];
    end
  end

  always_ff @(posedge link.core_clk) begin
    if (link.rst) begin
      save_pend_ff <= 1'b0;
      load_pend_ff <= 1'b0;
    end else begin
      // A new request in the cycle the old one is served is kept
      save_pend_ff <= link.save_req ||
                      (save_pend_ff && !(in_idle_raw && !load_pend_ff));
      load_pend_ff <= link.setup_done ||
                      (load_pend_ff && !in_idle_raw);
    end
  end

  always_ff @(posedge link.core_clk) begin
    if (link.rst) begin
      state_ff <= ST_LOAD;
      idx_ff <= '0;
      remain_ff <= '0;
      type_ff <= '0;
      err_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rsp_last_ff <= 1'b0;
      rsp_data_ff <= '0;
    end else begin
      rsp_valid_ff <= 1'b0;
      rsp_last_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      case (state_ff)
        ST_LOAD, ST_SAVE: begin
          idx_ff <= copy_end ? '0 : idx_ff + 1'b1;
          if (copy_end) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (load_pend_ff) begin
            state_ff <= ST_LOAD;
            idx_ff <= '0;
          end else if (save_pend_ff) begin
            state_ff <= ST_SAVE;
            idx_ff <= '0;
          end else if (hdr_take) begin
            type_ff <= q.ptype;
            err_ff <= !hdr_ok;
            idx_ff <= base_idx + 1'b1;
            remain_ff <= q.count - 1'b1;
            if (hdr_ok && !q.write) begin
              state_ff <= ST_READ;
              idx_ff <= base_idx;
              remain_ff <= q.count;
            end else if (q.write && q.first && q.count > 16'h0001) begin
              state_ff <= ST_WRITE;
            end else begin
              rsp_valid_ff <= 1'b1;
              rsp_last_ff <= 1'b1;
              rsp_err_ff <= !hdr_ok;
            end
          end
        end
        ST_WRITE: begin
          if (beat_take) begin
            idx_ff <= idx_ff + 1'b1;
            remain_ff <= remain_ff - 1'b1;
            if (!beat_ok) begin
              err_ff <= 1'b1;
            end
            if (remain_ff == 16'h0001) begin
              state_ff <= ST_IDLE;
              rsp_valid_ff <= 1'b1;
              rsp_last_ff <= 1'b1;
              rsp_err_ff <= !beat_ok || err_ff;
            end
          end
        end
        ST_READ: begin
          rsp_valid_ff <= 1'b1;
          rsp_data_ff <= work[idx_ff];
          idx_ff <= idx_ff + 1'b1;
          remain_ff <= remain_ff - 1'b1;
          if (remain_ff == 16'h0001) begin
            rsp_last_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link.core_clk) begin
    if (link.rst) begin
      busy_ff <= 1'b1;
      loading_ff <= 1'b1;
      saving_ff <= 1'b0;
    end else begin
      busy_ff <= !in_idle_raw || save_pend_ff || load_pend_ff;
      loading_ff <= (state_ff == ST_LOAD) && !copy_end;
      saving_ff <= (state_ff == ST_SAVE) && !copy_end;
    end
  end

  assign link.rsp_valid = rsp_valid_ff;
  assign link.rsp_err = rsp_err_ff;
  assign link.rsp_last = rsp_last_ff;
  assign link.rsp_data = rsp_data_ff;
  assign link.busy = busy_ff;
  assign loading = loading_ff;
  assign saving = saving_ff;
endmodule

// [pts_pkg.sv]
package pts_pkg;
  localparam int WORD_W = 16;
  localparam logic [15:0] TYPE_COMMON = 16'h0100;
  localparam logic [15:0] TYPE_AXIS_FIRST = 16'h0201;
  localparam logic [15:0] TYPE_AXIS_LAST = 16'h0210;
  localparam logic [15:0] COMMON_ADDR_MIN = 16'h0001;
  localparam logic [15:0] COMMON_ADDR_MAX = 16'h0013;
  localparam logic [15:0] AXIS_ADDR_MAX = 16'h007c;
  // Common words up to this address apply only at start-up or setup
  localparam logic [15:0] BOOT_ONLY_MAX = 16'h0004;
  localparam int COMMON_WORDS = int'(COMMON_ADDR_MAX) + 1;
  localparam int AXIS_WORDS = int'(AXIS_ADDR_MAX) + 1;
  localparam int AXES = int'(TYPE_AXIS_LAST - TYPE_AXIS_FIRST) + 1;
  localparam int STORE_WORDS = COMMON_WORDS + AXES * AXIS_WORDS;
  localparam int IDX_W = $clog2(STORE_WORDS);
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    PTS_BITS = 2'b00,
    PTS_BLOCK = 2'b01,
    PTS_TOOL = 2'b10
  } pts_method_t;

  typedef struct packed {
    logic first;
    logic write;
    pts_method_t method;
    logic [15:0] ptype;
    logic [15:0] addr;
    logic [15:0] count;
    logic [WORD_W-1:0] data;
  } pts_beat_t;
endpackage

// [pts_if.sv]
`timescale 1ns/100ps
interface pts_if import pts_pkg::*; (
  input logic core_clk,
  input logic rst
);
  pts_beat_t beat;
  logic req_valid;
  logic req_ready;
  logic xfer_bit;
  logic host_running;
  logic setup_mode;
  logic setup_done;
  logic save_req;
  logic rsp_valid;
  logic rsp_err;
  logic rsp_last;
  logic [WORD_W-1:0] rsp_data;
  logic busy;

  modport dev (
    input core_clk, rst, beat, req_valid, xfer_bit, host_running,
    input setup_mode, setup_done, save_req,
    output req_ready, rsp_valid, rsp_err, rsp_last, rsp_data, busy
  );
  modport host (
    input core_clk, rst, req_ready, rsp_valid, rsp_err, rsp_last,
    input rsp_data, busy,
    output beat, req_valid, xfer_bit, host_running, setup_mode,
    output setup_done, save_req
  );
endinterface

// [pts_host.sv]
`timescale 1ns/100ps
module pts_host import pts_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command
  input wire logic cmd_start,
  input wire logic cmd_write,
  input wire pts_method_t cmd_method,
  input wire logic [15:0] cmd_type,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_count,
  output logic cmd_busy,
  // Write words
  input wire logic [WORD_W-1:0] wdata,
  input wire logic wdata_valid,
  output logic wdata_ack,
  // Read words and completion
  output logic [WORD_W-1:0] rdata,
  output logic rdata_valid,
  output logic done,
  output logic err,
  // Controller state
  input wire logic plc_running,
  input wire logic setup_active,
  input wire logic setup_finish,
  input wire logic save_start,
  // Link to the device
  pts_if.host link
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_WAIT = 2'b10
  } pts_hstate_t;

  pts_hstate_t state_ff;
  pts_beat_t cmd_ff;
  pts_beat_t beat_ff;
  logic beat_valid_ff;
  logic [15:0] sent_ff;
  logic xfer_bit_ff;
  logic ack_ff;
  logic busy_ff;
  logic [WORD_W-1:0] rdata_ff;
  logic rdata_valid_ff;
  logic done_ff;
  logic err_ff;
  logic running_ff;
  logic setup_ff;
  logic setup_done_ff;
  logic save_ff;

  wire blk_refuse = (cmd_method == PTS_BLOCK) && !plc_running;
  wire consumed = beat_valid_ff && link.req_ready;
  wire more = (sent_ff < cmd_ff.count);
  // A header goes out even with a zero count, so it still gets its refusal
  wire grab_wr = cmd_ff.write && (more || sent_ff == '0) && wdata_valid &&
                 !ack_ff;
  wire grab_rd = !cmd_ff.write && (sent_ff == '0);
  wire grab = (state_ff == HS_SEND) && !beat_valid_ff && (grab_wr || grab_rd);
  wire all_sent = !more && !beat_valid_ff && (sent_ff != '0);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= HS_IDLE;
      cmd_ff <= '0;
      beat_ff <= '0;
      beat_valid_ff <= 1'b0;
      sent_ff <= '0;
      xfer_bit_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= '0;
      rdata_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= 1'b0;
      rdata_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      if (consumed) begin
        beat_valid_ff <= 1'b0;
      end
      if (grab) begin
        beat_ff <= cmd_ff;
        beat_ff.first <= (sent_ff == '0);
        beat_ff.addr <= cmd_ff.addr + sent_ff;
        beat_ff.data <= cmd_ff.write ? wdata : '0;
        beat_valid_ff <= 1'b1;
        sent_ff <= cmd_ff.write ? sent_ff + 1'b1 : '1;
        ack_ff <= cmd_ff.write;
      end
      case (state_ff)
        HS_IDLE: begin
          if (cmd_start && blk_refuse) begin
            done_ff <= 1'b1;
            err_ff <= 1'b1;
          end else if (cmd_start) begin
            // One area and one item per command keeps each block write
            // within a single sequence
            cmd_ff <= '{first: 1'b1, write: cmd_write, method: cmd_method,
                        ptype: cmd_type, addr: cmd_addr, count: cmd_count,
                        data: '0};
            sent_ff <= '0;
            err_ff <= 1'b0;
            xfer_bit_ff <= (cmd_method == PTS_BITS);
            state_ff <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (all_sent && !grab) begin
            state_ff <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (link.rsp_valid) begin
            rdata_ff <= link.rsp_data;
            rdata_valid_ff <= !cmd_ff.write && !link.rsp_err;
            if (link.rsp_last) begin
              done_ff <= 1'b1;
              err_ff <= link.rsp_err;
              xfer_bit_ff <= 1'b0;
              state_ff <= HS_IDLE;
            end
          end
        end
        default: begin
          state_ff <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      running_ff <= 1'b0;
      setup_ff <= 1'b0;
      setup_done_ff <= 1'b0;
      save_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != HS_IDLE) || (cmd_start && !blk_refuse);
      running_ff <= plc_running;
      setup_ff <= setup_active;
      setup_done_ff <= setup_finish;
      save_ff <= save_start;
    end
  end

  assign link.beat = beat_ff;
  assign link.req_valid = beat_valid_ff;
  assign link.xfer_bit = xfer_bit_ff;
  assign link.host_running = running_ff;
  assign link.setup_mode = setup_ff;
  assign link.setup_done = setup_done_ff;
  assign link.save_req = save_ff;
  assign cmd_busy = busy_ff;
  assign wdata_ack = ack_ff;
  assign rdata = rdata_ff;
  assign rdata_valid = rdata_valid_ff;
  assign done = done_ff;
  assign err = err_ff;
endmodule

// [pts_asserts.sv]
`timescale 1ns/100ps
module pts_asserts import pts_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Requests
  input wire pts_beat_t beat,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic host_running,
  input wire logic setup_done,
  input wire logic save_req,
  // Answers
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic rsp_last,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Only headers taken while idle, so a pending load cannot stretch the wait
  wire logic hdr = req_valid && req_ready && beat.first && !busy;
  wire logic ans_err = rsp_valid && rsp_err && rsp_last;
  wire logic com = beat.ptype == TYPE_COMMON;

  AST_BLOCK_READ: assert property (
    hdr && !beat.write && beat.method == PTS_BLOCK |-> ##[1:20] ans_err)
    else $error("block read was not refused");
  AST_COMMON_RANGE: assert property (
    hdr && com && (beat.addr < COMMON_ADDR_MIN ||
    beat.addr > COMMON_ADDR_MAX) |-> ##[1:20] ans_err)
    else $error("common address outside range not refused");
  AST_TYPE_DECODE: assert property (
    hdr && !com && (beat.ptype < TYPE_AXIS_FIRST ||
    beat.ptype > TYPE_AXIS_LAST) |-> ##[1:20] ans_err)
    else $error("unknown type code not refused");
  AST_BOOT_ONLY: assert property (
    hdr && beat.write && beat.method == PTS_BLOCK && com &&
    beat.addr <= BOOT_ONLY_MAX |-> ##[1:20] ans_err)
    else $error("block write to start-up word not refused");
  AST_BITS_ANY_MODE: assert property (
    hdr && beat.write && beat.method == PTS_BITS && !host_running &&
    beat.ptype == TYPE_AXIS_LAST && beat.addr == 16'h0000 &&
    beat.count == 16'h0001 |-> ##[1:20] rsp_valid && rsp_last && !rsp_err)
    else $error("transfer bit write refused while stopped");
  AST_ERR_ENDS: assert property (
    rsp_valid && rsp_err |-> rsp_last)
    else $error("error answer not marked last");
  AST_LOAD_AFTER_RESET: assert property (
    $fell(rst) |-> busy [*8])
    else $error("no reload after reset");
  AST_SAVE_BUSY: assert property (
    save_req |-> ##[1:3] busy)
    else $error("save request ignored");
  AST_SETUP_LOAD: assert property (
    setup_done |-> ##[1:3] busy)
    else $error("setup end did not reload");
endmodule

// [pts_tb.sv]
`timescale 1ns/100ps
module pts_tb import pts_pkg::*;;
  typedef struct packed {
    logic w;
    pts_method_t m;
    logic [15:0] t;
    logic [15:0] a;
    logic [1:0] c;
    logic [31:0] d;
    logic run;
    logic e;
  } pts_row_t;

  logic core_clk, rst, cmd_start, cmd_write, cmd_busy, wdata_valid;
  logic wdata_ack, rdata_valid, done, err, plc_running, setup_active;
  logic setup_finish, save_start;
  pts_method_t cmd_method;
  logic [15:0] cmd_type, cmd_addr, cmd_count, wdata, rdata;
  logic loading, saving;
  int n_errors, tests_run, n_ack;
  pts_row_t rows [16];

  pts_if pts_if_inst (.core_clk(core_clk), .rst(rst));
  pts_device #(.DEPTH(8)) pts_device_inst (.link(pts_if_inst.dev),
    .loading(loading), .saving(saving));
  pts_host pts_host_inst (.core_clk(core_clk), .rst(rst),
    .cmd_start(cmd_start), .cmd_write(cmd_write), .cmd_method(cmd_method),
    .cmd_type(cmd_type), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
    .cmd_busy(cmd_busy), .wdata(wdata), .wdata_valid(wdata_valid),
    .wdata_ack(wdata_ack), .rdata(rdata), .rdata_valid(rdata_valid),
    .done(done), .err(err), .plc_running(plc_running),
    .setup_active(setup_active), .setup_finish(setup_finish),
    .save_start(save_start), .link(pts_if_inst.host));
  pts_asserts pts_asserts_inst (.core_clk(core_clk), .rst(rst),
    .beat(pts_if_inst.beat), .req_valid(pts_if_inst.req_valid),
    .req_ready(pts_if_inst.req_ready),
    .host_running(pts_if_inst.host_running),
    .setup_done(pts_if_inst.setup_done), .save_req(pts_if_inst.save_req),
    .rsp_valid(pts_if_inst.rsp_valid), .rsp_err(pts_if_inst.rsp_err),
    .rsp_last(pts_if_inst.rsp_last), .busy(pts_if_inst.busy));

  always #20 core_clk = ~core_clk;

  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Load and save each take one full pass over the store
  task automatic wait_idle();
    int n;
    // Busy rises only a few cycles after a load or save request
    repeat (3) @(negedge core_clk);
    for (n = 0; n < 3000 && pts_if_inst.busy !== 1'h0; n++) begin
      @(negedge core_clk);
    end
    if (n == 3000) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic run(input pts_row_t r);
    int k;
    int n;
    logic [15:0] w [2];
    w = '{r.d[31:16], r.d[15:0]};
    k = 0;
    plc_running = r.run;
    @(negedge core_clk);
    cmd_write = r.w;
    cmd_method = r.m;
    cmd_type = r.t;
    cmd_addr = r.a;
    cmd_count = 16'(r.c);
    wdata = w[0];
    wdata_valid = r.w;
    cmd_start = 1'h1;
    @(negedge core_clk);
    cmd_start = 1'h0;
    for (n = 0; n < 3000 && done !== 1'h1; n++) begin
      @(negedge core_clk);
      if (wdata_ack === 1'h1) begin
        k++;
        wdata = w[k % 2];
      end
      if (rdata_valid === 1'h1) begin
        check(rdata, w[k % 2], "rdata");
        k++;
      end
    end
    wdata_valid = 1'h0;
    if (n == 3000) begin
      n_errors++;
      report_and_stop();
    end
    check(16'(err), 16'(r.e), "err");
    if (!r.e) check(16'(k), 16'(r.c), "words");
  endtask

  initial begin
    core_clk = 1'h0;
    rst = 1'h1;
    {cmd_start, cmd_write, wdata_valid, plc_running} = 4'h0;
    {setup_active, setup_finish, save_start} = 3'h0;
    cmd_method = PTS_BITS;
    {cmd_type, cmd_addr, cmd_count, wdata} = 64'h0;
    n_ack = 0;
    n_errors = 0;
    tests_run = 0;
    repeat (8) @(negedge core_clk);
    rst = 1'h0;
    wait_idle();
    rows = '{
      '{1'h1, PTS_TOOL, 16'h0100, 16'h0001, 2'h2, 32'h11112222, 1'h1, 1'h0},
      '{1'h0, PTS_BITS, 16'h0100, 16'h0001, 2'h2, 32'h11112222, 1'h1, 1'h0},
      '{1'h1, PTS_BLOCK, 16'h0201, 16'h007b, 2'h2, 32'ha1a1b2b2, 1'h1, 1'h0},
      '{1'h0, PTS_TOOL, 16'h0201, 16'h007b, 2'h2, 32'ha1a1b2b2, 1'h1, 1'h0},
      '{1'h1, PTS_BITS, 16'h0210, 16'h0000, 2'h1, 32'h3c3c0000, 1'h0, 1'h0},
      '{1'h0, PTS_BITS, 16'h0210, 16'h0000, 2'h1, 32'h3c3c0000, 1'h0, 1'h0},
      '{1'h0, PTS_BLOCK, 16'h0100, 16'h0005, 2'h1, 32'h0, 1'h1, 1'h1},
      '{1'h1, PTS_BLOCK, 16'h0100, 16'h0002, 2'h1, 32'hdead0000, 1'h1, 1'h1},
      '{1'h1, PTS_BITS, 16'h0100, 16'h0003, 2'h1, 32'hdead0000, 1'h1, 1'h1},
      '{1'h1, PTS_TOOL, 16'h0200, 16'h0000, 2'h1, 32'h0, 1'h1, 1'h1},
      '{1'h1, PTS_TOOL, 16'h0211, 16'h0000, 2'h1, 32'h0, 1'h1, 1'h1},
      '{1'h1, PTS_TOOL, 16'h0100, 16'h0000, 2'h1, 32'hdead0000, 1'h1, 1'h1},
      '{1'h1, PTS_TOOL, 16'h0201, 16'h007c, 2'h2, 32'h0, 1'h1, 1'h1},
      '{1'h1, PTS_BLOCK, 16'h0201, 16'h0000, 2'h1, 32'h0, 1'h0, 1'h1},
      '{1'h1, PTS_TOOL, 16'h0201, 16'h0000, 2'h0, 32'h0, 1'h1, 1'h1},
      '{1'h0, PTS_TOOL, 16'h0100, 16'h0001, 2'h2, 32'h11112222, 1'h1, 1'h0}
    };
    foreach (rows[i]) run(rows[i]);
    setup_active = 1'h1;
    run('{1'h1, PTS_BITS, 16'h0100, 16'h0004, 2'h1, 32'h77770000, 1'h0,
      1'h0});
    setup_active = 1'h0;
    save_start = 1'h1;
    @(negedge core_clk);
    save_start = 1'h0;
    repeat (4) @(negedge core_clk);
    check(16'(saving), 16'h1, "saving");
    check(16'(cmd_busy), 16'h0, "host idle");
    wait_idle();
    run('{1'h1, PTS_TOOL, 16'h0210, 16'h0000, 2'h1, 32'h55550000, 1'h1,
      1'h0});
    setup_finish = 1'h1;
    @(negedge core_clk);
    setup_finish = 1'h0;
    wait_idle();
    run('{1'h0, PTS_TOOL, 16'h0210, 16'h0000, 2'h1, 32'h3c3c0000, 1'h1,
      1'h0});
    rst = 1'h1;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    // Nine words sent during the reload: eight fill the queue, one waits
    cmd_write = 1'h1;
    cmd_method = PTS_TOOL;
    cmd_type = 16'h0201;
    cmd_addr = 16'h0000;
    cmd_count = 16'h0009;
    wdata = 16'h6a00;
    wdata_valid = 1'h1;
    cmd_start = 1'h1;
    @(negedge core_clk);
    cmd_start = 1'h0;
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if (wdata_ack === 1'h1) begin
        n_ack++;
        wdata = 16'h6a00 + 16'(n_ack);
      end
    end
    check(16'(n_ack), 16'h9, "words queued");
    for (int i = 0; i < 8; i++) begin
      check(16'(pts_if_inst.req_ready), 16'h0, "queue full");
      check(16'(pts_if_inst.req_valid), 16'h1, "beat held");
      check(16'(loading), 16'h1, "loading");
      check(16'(cmd_busy), 16'h1, "host busy");
      @(negedge core_clk);
    end
    for (int i = 0; i < 3000 && done !== 1'h1; i++) begin
      @(negedge core_clk);
    end
    wdata_valid = 1'h0;
    check(16'(done), 16'h1, "queued write done");
    check(16'(err), 16'h0, "queued write err");
    if (done !== 1'h1) begin
      report_and_stop();
    end
    run('{1'h0, PTS_TOOL, 16'h0201, 16'h0000, 2'h1, 32'h6a000000, 1'h1,
      1'h0});
    run('{1'h0, PTS_TOOL, 16'h0201, 16'h0008, 2'h1, 32'h6a080000, 1'h1,
      1'h0});
    run('{1'h0, PTS_TOOL, 16'h0100, 16'h0004, 2'h1, 32'h77770000, 1'h1,
      1'h0});
    report_and_stop();
  end
endmodule
